// ### verilog/bkosc_defs.svh
`ifndef BKOSC_DEFS_SVH
`define BKOSC_DEFS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define BKOSC_CTRL_OFS      8'h00
`define BKOSC_SEL_OFS       8'h04
`define BKOSC_STAT_OFS      8'h08
`define BKOSC_GATE_OFS      8'h0C
`define BKOSC_STAB_OFS      8'h10
`define BKOSC_WDOG_OFS      8'h14

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define BKOSC_CTRL_SUB_BIT  0
`define BKOSC_CTRL_REQ_BIT  1

// ----------------------------------------
// Clock-select register fields
// ----------------------------------------
`define BKOSC_SEL_T16B_WT   0
`define BKOSC_SEL_WT_SUB    1
`define BKOSC_SEL_T8_EXT0   2
`define BKOSC_SEL_T8_EXT1   3
`define BKOSC_SEL_T8_CMP0   4
`define BKOSC_SEL_T8_CMP1   5
`define BKOSC_SEL_IT1_2048  6
`define BKOSC_SEL_WD_DIV8   7
`define BKOSC_SEL_CS0_EXT   8
`define BKOSC_SEL_CS1_EXT   9
`define BKOSC_SEL_AS0_EXT   10
`define BKOSC_SEL_RTO_EN    11
`define BKOSC_SEL_RTO_SRC   12

// ----------------------------------------
// Gate output bit positions
// ----------------------------------------
`define BKOSC_G_T16A        0
`define BKOSC_G_T16B        1
`define BKOSC_G_T8_0        2
`define BKOSC_G_T8_1        3
`define BKOSC_G_IT0         4
`define BKOSC_G_IT1         5
`define BKOSC_G_WT          6
`define BKOSC_G_WD1         7
`define BKOSC_G_WD2         8
`define BKOSC_G_CS0         9
`define BKOSC_G_CS1         10
`define BKOSC_G_TWS         11
`define BKOSC_G_AS0         12
`define BKOSC_G_AS1         13
`define BKOSC_G_ADC         14
`define BKOSC_G_RTO         15
`define BKOSC_G_CMON        16
`define BKOSC_G_ROMC        17
`define BKOSC_G_INTC        18
`define BKOSC_G_KEY         19
`define BKOSC_G_POC         20
`define BKOSC_G_LVD         21
`define BKOSC_G_PORT        22
`define BKOSC_GATES         23

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define BKOSC_SEL_RST       32'h0000_0000
`define BKOSC_STAB_RST      32'h0000_0100
`define BKOSC_WDOG_RST      32'h0000_0400

`endif

// ### verilog/bkosc_pkg.sv
package bkosc_pkg;

    typedef enum logic [1:0] {
        BKOSC_RESET,
        BKOSC_WAIT,
        BKOSC_NORMAL,
        BKOSC_BACKUP
    } bkosc_mode_t;

    typedef struct packed {
        bkosc_mode_t mode;
        logic        sub_used;
        logic [12:0] sel;
        logic [31:0] stab_limit;
        logic [31:0] wdog_limit;
        logic [31:0] stab_cnt;
        logic [31:0] wdog_cnt;
        logic        ack;
        logic [31:0] dat;
    } bkosc_state_t;

endpackage : bkosc_pkg

// ### verilog/bkosc_ctrl.sv
// Operation
// - Backup mode exits only through reset
// - Stabilization counter first: enter normal mode
// - Watchdog first during wait: enter backup
// - Second 16-bit timer needs watch-timer subclock
// - 8-bit timer runs from external pin
// - 8-bit timer chained to enabled 16-bit timer
// - Interval timer one needs divide-2048 clock
// - Watch timer needs subclock selected
// - Second watchdog: divide-8 clock, or subclock in use
// - Clocked serial only with external clock
// - First async serial needs external baud
// - Real-time output needs enabled 8-bit timer
`timescale 1ns/100ps
`include "bkosc_defs.svh"
`default_nettype none

module bkosc_ctrl
(
    // Clock and reset
    input  wire logic                    REF_CLK,
    input  wire logic                    RST_N,
    // Wishbone slave
    input  wire logic                    CYC_I,
    input  wire logic                    STB_I,
    input  wire logic                    WE_I,
    input  wire logic [7:0]              ADR_I,
    input  wire logic [3:0]              SEL_I,
    input  wire logic [31:0]             DAT_I,
    output logic      [31:0]             DAT_O,
    output logic                         ACK_O,
    output logic                         ERR_O,
    // Mode and gates
    output logic                         BACKUP_MODE,
    output logic                         NORMAL_MODE,
    output logic [`BKOSC_GATES-1:0]      CLK_RUN
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    bkosc_pkg::bkosc_state_t st;
    bkosc_pkg::bkosc_state_t next_st;

    logic        req;
    logic        bk;
    logic [`BKOSC_GATES-1:0] gate;
    logic        t16b_on;
    logic        t8_on0;
    logic        t8_on1;
    logic        mapped;

    assign req    = CYC_I && STB_I && !st.ack;
    assign bk     = (st.mode == bkosc_pkg::BKOSC_BACKUP);
    assign mapped = (ADR_I == `BKOSC_CTRL_OFS) || (ADR_I == `BKOSC_SEL_OFS)
                 || (ADR_I == `BKOSC_STAT_OFS) || (ADR_I == `BKOSC_GATE_OFS)
                 || (ADR_I == `BKOSC_STAB_OFS) || (ADR_I == `BKOSC_WDOG_OFS);

    // ----------------------------------------
    // Peripheral gating
    // ----------------------------------------
    // Watch-timer chained 16-bit timer
    assign t16b_on = st.sub_used && st.sel[`BKOSC_SEL_T16B_WT] && st.sel[`BKOSC_SEL_WT_SUB];
    assign t8_on0  = st.sel[`BKOSC_SEL_T8_EXT0]
                  || (st.sub_used && st.sel[`BKOSC_SEL_T8_CMP0] && t16b_on);
    assign t8_on1  = st.sel[`BKOSC_SEL_T8_EXT1]
                  || (st.sub_used && st.sel[`BKOSC_SEL_T8_CMP1] && t16b_on);

    always_comb
    begin
        gate = '0;
        gate[`BKOSC_G_T16B] = t16b_on;
        gate[`BKOSC_G_T8_0] = t8_on0;
        gate[`BKOSC_G_T8_1] = t8_on1;
        gate[`BKOSC_G_IT1]  = st.sel[`BKOSC_SEL_IT1_2048];
        gate[`BKOSC_G_WT]   = st.sub_used && st.sel[`BKOSC_SEL_WT_SUB];
        gate[`BKOSC_G_WD2]  = st.sub_used || st.sel[`BKOSC_SEL_WD_DIV8];
        gate[`BKOSC_G_CS0]  = st.sel[`BKOSC_SEL_CS0_EXT];
        gate[`BKOSC_G_CS1]  = st.sel[`BKOSC_SEL_CS1_EXT];
        gate[`BKOSC_G_AS0]  = st.sel[`BKOSC_SEL_AS0_EXT];
        gate[`BKOSC_G_RTO]  = st.sel[`BKOSC_SEL_RTO_EN]
                           && (st.sel[`BKOSC_SEL_RTO_SRC] ? t8_on1 : t8_on0);
        gate[`BKOSC_G_ROMC] = 1'b1;
        gate[`BKOSC_G_INTC] = 1'b1;
        gate[`BKOSC_G_KEY]  = 1'b1;
        gate[`BKOSC_G_POC]  = 1'b1;
        gate[`BKOSC_G_LVD]  = 1'b1;
        gate[`BKOSC_G_PORT] = 1'b1;
    end

    // In normal mode every unit runs; in reset/wait every gate is off, support functions included
    always_comb
    begin
        if (st.mode == bkosc_pkg::BKOSC_NORMAL)
            CLK_RUN = '1;
        else if (bk)
            CLK_RUN = gate;
        else
            CLK_RUN = '0;
    end

    assign BACKUP_MODE = bk;
    assign NORMAL_MODE = (st.mode == bkosc_pkg::BKOSC_NORMAL);
    assign DAT_O       = st.dat;
    assign ACK_O       = st.ack && mapped;
    assign ERR_O       = st.ack && !mapped;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        next_st     = st;
        next_st.ack = req;
        unique case (st.mode)
            bkosc_pkg::BKOSC_RESET:
            begin
                next_st.mode     = bkosc_pkg::BKOSC_WAIT;
                next_st.stab_cnt = '0;
                next_st.wdog_cnt = '0;
            end
            bkosc_pkg::BKOSC_WAIT:
            begin
                next_st.stab_cnt = st.stab_cnt + 32'h0000_0001;
                next_st.wdog_cnt = st.wdog_cnt + 32'h0000_0001;
                if (st.wdog_cnt >= st.wdog_limit)
                    next_st.mode = bkosc_pkg::BKOSC_BACKUP;
                else if (st.stab_cnt >= st.stab_limit)
                    next_st.mode = bkosc_pkg::BKOSC_NORMAL;
            end
            bkosc_pkg::BKOSC_NORMAL:
            begin
                // Software restart of the wait models a stop-mode release
                if (req && WE_I && SEL_I[0] && (ADR_I == `BKOSC_CTRL_OFS)
                    && DAT_I[`BKOSC_CTRL_REQ_BIT])
                    next_st.mode = bkosc_pkg::BKOSC_RESET;
            end
            bkosc_pkg::BKOSC_BACKUP:
            begin
                next_st.mode = bkosc_pkg::BKOSC_BACKUP;
            end
        endcase

        next_st.dat = '0;
        if (req && !WE_I)
        begin
            unique case (ADR_I)
                `BKOSC_CTRL_OFS: next_st.dat = {31'h0, st.sub_used};
                `BKOSC_SEL_OFS:  next_st.dat = {19'h0, st.sel};
                `BKOSC_STAT_OFS: next_st.dat = {30'h0, st.mode};
                `BKOSC_GATE_OFS: next_st.dat = {9'h0, CLK_RUN};
                `BKOSC_STAB_OFS: next_st.dat = st.stab_limit;
                `BKOSC_WDOG_OFS: next_st.dat = st.wdog_limit;
                default:         next_st.dat = '0;
            endcase
        end
        if (req && WE_I)
        begin
            unique case (ADR_I)
                `BKOSC_CTRL_OFS:
                    if (SEL_I[0])
                        next_st.sub_used = DAT_I[`BKOSC_CTRL_SUB_BIT];
                `BKOSC_SEL_OFS:
                begin
                    if (SEL_I[0])
                        next_st.sel[7:0] = DAT_I[7:0];
                    if (SEL_I[1])
                        next_st.sel[12:8] = DAT_I[12:8];
                end
                `BKOSC_STAB_OFS:
                    for (int i = 0; i < 4; i++)
                        if (SEL_I[i])
                            next_st.stab_limit[i*8 +: 8] = DAT_I[i*8 +: 8];
                `BKOSC_WDOG_OFS:
                    for (int i = 0; i < 4; i++)
                        if (SEL_I[i])
                            next_st.wdog_limit[i*8 +: 8] = DAT_I[i*8 +: 8];
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            st            <= '0;
            st.mode       <= bkosc_pkg::BKOSC_RESET;
            st.sel        <= 13'(`BKOSC_SEL_RST);
            st.stab_limit <= `BKOSC_STAB_RST;
            st.wdog_limit <= `BKOSC_WDOG_RST;
        end
        else
            st <= next_st;
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    a_backup_sticky: assert property (bk |=> bk)
        else $error("backup mode left without reset");
    a_stab_normal: assert property ((st.mode == bkosc_pkg::BKOSC_WAIT
        && st.stab_cnt >= st.stab_limit && st.wdog_cnt < st.wdog_limit)
        |=> NORMAL_MODE)
        else $error("stable oscillator did not reach normal mode");
    a_wdog_backup: assert property ((st.mode == bkosc_pkg::BKOSC_WAIT
        && st.wdog_cnt >= st.wdog_limit) |=> bk)
        else $error("watchdog overflow did not enter backup");
    a_t16b_gate: assert property (bk && !t16b_on |-> !CLK_RUN[`BKOSC_G_T16B])
        else $error("second 16-bit timer ran without watch clock");
    a_t8_gate: assert property (bk && !st.sub_used && !st.sel[`BKOSC_SEL_T8_EXT0]
        |-> !CLK_RUN[`BKOSC_G_T8_0])
        else $error("8-bit timer ran without external input");
    a_t8_chain: assert property (bk && st.sub_used && t16b_on
        && st.sel[`BKOSC_SEL_T8_CMP1] |-> CLK_RUN[`BKOSC_G_T8_1])
        else $error("chained 8-bit timer stopped");
    a_it1_gate: assert property (bk |-> CLK_RUN[`BKOSC_G_IT1]
        == st.sel[`BKOSC_SEL_IT1_2048])
        else $error("interval timer gate wrong");
    a_wt_gate: assert property (bk && !st.sub_used |-> !CLK_RUN[`BKOSC_G_WT])
        else $error("watch timer ran without subclock");
    a_wd2_gate: assert property (bk && st.sub_used |-> CLK_RUN[`BKOSC_G_WD2])
        else $error("watchdog stopped with subclock");
    a_cs_gate: assert property (bk && !st.sel[`BKOSC_SEL_CS0_EXT]
        |-> !CLK_RUN[`BKOSC_G_CS0])
        else $error("clocked serial ran without external clock");
    a_as0_gate: assert property (bk && !st.sel[`BKOSC_SEL_AS0_EXT]
        |-> !CLK_RUN[`BKOSC_G_AS0])
        else $error("async serial ran without external baud");
    a_rto_gate: assert property (bk && CLK_RUN[`BKOSC_G_RTO]
        |-> (CLK_RUN[`BKOSC_G_T8_0] || CLK_RUN[`BKOSC_G_T8_1]))
        else $error("real-time output ran without its timer");
    a_stopped_units: assert property (bk |-> !CLK_RUN[`BKOSC_G_T16A]
        && !CLK_RUN[`BKOSC_G_ADC] && !CLK_RUN[`BKOSC_G_CMON]
        && !CLK_RUN[`BKOSC_G_TWS] && !CLK_RUN[`BKOSC_G_AS1])
        else $error("held unit ran in backup mode");
    a_support_on: assert property (bk |-> CLK_RUN[`BKOSC_G_INTC]
        && CLK_RUN[`BKOSC_G_PORT] && CLK_RUN[`BKOSC_G_POC])
        else $error("support function stopped in backup mode");
    a_bus_ack: assert property (CYC_I && STB_I && !st.ack |=> (ACK_O || ERR_O))
        else $error("bus request not answered in one cycle");

    c_to_normal: cover property (st.mode == bkosc_pkg::BKOSC_WAIT ##1 NORMAL_MODE);
    c_to_backup: cover property (st.mode == bkosc_pkg::BKOSC_WAIT ##1 bk);
    c_chain_run: cover property (bk && CLK_RUN[`BKOSC_G_T8_0] && st.sel[`BKOSC_SEL_T8_CMP0]);
    c_rto_run:   cover property (bk && CLK_RUN[`BKOSC_G_RTO]);

endmodule : bkosc_ctrl

`default_nettype wire

// ### verif/bkosc_rst_src.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Reset sources seen by the block
// ----------------------------------------
module bkosc_rst_src
(
    // Clock
    input  wire logic clk,
    // Watchdog reset request, one-cycle pulse
    input  wire logic wdog_req,
    // Reset out, active low
    output logic      rst_n
);
    int cnt = 4;

    // Power-on hold of four cycles, then a short hold per watchdog request
    always @(posedge clk)
    begin
        if (wdog_req)
            cnt <= 3;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end

    assign rst_n = (cnt == 0) && !wdog_req;
endmodule : bkosc_rst_src

`default_nettype wire

// ### verif/bkosc_tb_top.sv
`timescale 1ns/100ps
`include "bkosc_defs.svh"
`default_nettype none

module bkosc_tb_top;
    logic                    clk = 1'b0;
    logic                    rst_n;
    logic                    wdog_req = 1'b0;
    logic                    cyc = 1'b0;
    logic                    we = 1'b0;
    logic [7:0]              adr = 8'h00;
    logic [31:0]             wdat = 32'h0000_0000;
    logic [31:0]             rdat;
    logic                    ack;
    logic                    err;
    logic                    bk;
    logic                    nm;
    logic [`BKOSC_GATES-1:0] run;
    int                      failures = 0;
    int                      compares = 0;
    logic [31:0]             got;
    logic                    got_err;
    logic [12:0]             combo [7] = '{13'h0013, 13'h0023, 13'h0804, 13'h1808,
                                           13'h0813, 13'h1FFF, 13'h0000};

    always #5 clk = ~clk;

    bkosc_rst_src rsrc (.clk(clk), .wdog_req(wdog_req), .rst_n(rst_n));

    bkosc_ctrl dut
    (
        .REF_CLK(clk), .RST_N(rst_n), .CYC_I(cyc), .STB_I(cyc), .WE_I(we),
        .ADR_I(adr), .SEL_I(4'hF), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack),
        .ERR_O(err), .BACKUP_MODE(bk), .NORMAL_MODE(nm), .CLK_RUN(run)
    );

    // ----------------------------------------
    // Bus and checking tasks
    // ----------------------------------------
    task automatic end_of_test();
        if (failures == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Single classic cycle; answer is sampled at the edge after it appears
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        for (int i = 0; i < 20; i++)
        begin
            @(posedge clk);
            if (ack === 1'b1 || err === 1'b1)
            begin
                got     = rdat;
                got_err = err;
                cyc    <= 1'b0;
                return;
            end
        end
        check("bus answer", 32'h0, 32'h1);
        end_of_test();
    endtask : bus

    task automatic wait_mode(input logic want_backup);
        for (int i = 0; i < 2000; i++)
        begin
            @(posedge clk);
            if ((want_backup ? bk : nm) === 1'b1)
                return;
        end
        check("mode wait", 32'h0, 32'h1);
        end_of_test();
    endtask : wait_mode

    // Gate expectation in backup mode
    function automatic logic [`BKOSC_GATES-1:0] exp_run(input logic [12:0] s, input logic sub);
        logic [`BKOSC_GATES-1:0] g;
        g = '0;
        g[1] = sub & s[0] & s[1];
        g[2] = s[2] | (sub & s[4] & g[1]);
        g[3] = s[3] | (sub & s[5] & g[1]);
        g[5] = s[6];
        g[6] = sub & s[1];
        g[8] = sub | s[7];
        g[9] = s[8];
        g[10] = s[9];
        g[12] = s[10];
        g[15] = s[11] & (s[12] ? g[3] : g[2]);
        g[22:17] = '1;
        return g;
    endfunction : exp_run

    task automatic gate_case(input logic [12:0] s, input logic sub);
        bus(1'b1, `BKOSC_SEL_OFS, {19'h0, s});
        @(posedge clk);
        check("gates", {9'h0, run}, {9'h0, exp_run(s, sub)});
        check("backup", {31'h0, bk}, 32'h1);
    endtask : gate_case

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        // First request only once reset has been let go
        repeat (6) @(posedge clk);
        check("reset released", {31'h0, rst_n}, 32'h1);
        bus(1'b0, `BKOSC_STAB_OFS, 32'h0);
        check("stab reset", got, `BKOSC_STAB_RST);
        bus(1'b0, `BKOSC_WDOG_OFS, 32'h0);
        check("wdog reset", got, `BKOSC_WDOG_RST);
        check("gates in wait", {9'h0, run}, 32'h0);
        wait_mode(1'b0);
        @(posedge clk);
        check("normal gates", {9'h0, run}, 32'h007F_FFFF);
        bus(1'b1, `BKOSC_STAB_OFS, 32'h0000_FFFF);
        bus(1'b1, `BKOSC_WDOG_OFS, 32'h0000_0010);
        bus(1'b1, `BKOSC_CTRL_OFS, 32'h0000_0002);
        wait_mode(1'b1);
        check("normal off", {31'h0, nm}, 32'h0);
        bus(1'b1, `BKOSC_CTRL_OFS, 32'h0000_0003);
        repeat (40) @(posedge clk);
        bus(1'b0, `BKOSC_STAT_OFS, 32'h0);
        check("stays backup", got, 32'h3);
        bus(1'b1, `BKOSC_STAT_OFS, 32'h0000_0002);
        bus(1'b0, `BKOSC_STAT_OFS, 32'h0);
        check("stat read only", got, 32'h3);
        for (int sub = 0; sub < 2; sub++)
        begin
            bus(1'b1, `BKOSC_CTRL_OFS, sub);
            for (int i = 0; i < 13; i++)
                gate_case(13'h1 << i, sub[0]);
            foreach (combo[k])
                gate_case(combo[k], sub[0]);
        end
        bus(1'b0, 8'h40, 32'h0);
        check("unmapped err", {31'h0, got_err}, 32'h1);
        @(posedge clk);
        wdog_req <= 1'b1;
        @(posedge clk);
        wdog_req <= 1'b0;
        @(posedge clk);
        check("backup cleared", {31'h0, bk}, 32'h0);
        wait_mode(1'b0);
        check("normal again", {31'h0, nm}, 32'h1);
        check("backup off again", {31'h0, bk}, 32'h0);
        end_of_test();
    end
endmodule : bkosc_tb_top

`default_nettype wire
